// ==== dv/fics_core_model.sv ====
`timescale 1ns/1ps
// core side: a running counter and a flags byte, loaded on request
module fics_core_model (
  input logic clk,
  input logic sys_rst,
  input logic pc_load,
  input logic [15:0] pc_out,
  input logic flags_load,
  input logic [7:0] flags_out,
  output logic [15:0] pc_in,
  output logic [7:0] flags_in
);
  // pc keeps moving so every swap sees a fresh value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_in <= 16'h0100;
      flags_in <= 8'hA4;
    end else begin
      pc_in <= pc_load ? pc_out : pc_in + 16'h0001;
      if (flags_load) flags_in <= flags_out;
    end
  end
endmodule

// ==== dv/fics_properties.sv ====
`timescale 1ns/1ps
// port-level checks on entry and return timing
module fics_properties (
  input logic clk,
  input logic sys_rst,
  input logic irq_req,
  input logic instr_end,
  input logic interrupt_return_instr,
  input logic [7:0] flags_in,
  input logic irq_ack,
  input logic entry_busy,
  input logic entry_done,
  input logic pc_load,
  input logic flags_load,
  input logic [7:0] flags_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // a fast entry acks together with the core loads
  sequence fast_ack_s;
    irq_ack && pc_load;
  endsequence
  sequence ret_load_s;
    pc_load && !irq_ack;
  endsequence
  ack_at_end_a: assert property (irq_ack |-> $past(irq_req && instr_end))
    else $error("ack without instruction end");
  ack_when_idle_a: assert property (irq_ack |-> !$past(entry_busy))
    else $error("ack during entry");
  // busy rises one edge after the request edge, so it stands one cycle short
  fast_len_a: assert property (fast_ack_s |-> entry_busy [*5] ##1 !entry_busy)
    else $error("fast entry length wrong");
  norm_len_a: assert property (irq_ack && !pc_load |-> ##20 entry_busy ##1 !entry_busy)
    else $error("normal entry length wrong");
  done_last_a: assert property (entry_done |-> !entry_busy && $past(entry_busy))
    else $error("done not at end of entry");
  entry_flags_a: assert property (fast_ack_s |-> flags_load && flags_out == ($past(flags_in) | 8'h02))
    else $error("entry flags wrong");
  ret_cause_a: assert property (ret_load_s |-> $past(interrupt_return_instr && flags_in[1]))
    else $error("swap back without return");
  ret_flags_a: assert property (ret_load_s |-> flags_load && !flags_out[1])
    else $error("return flags wrong");
endmodule

bind fics_top fics_properties chk_u (.clk, .sys_rst, .irq_req, .instr_end,
  .interrupt_return_instr, .flags_in, .irq_ack, .entry_busy, .entry_done,
  .pc_load, .flags_load, .flags_out);

// ==== dv/test_fast_interrupt_context_swap.sv ====
`timescale 1ns/1ps
// register port and core events driven here, answers judged here and in the bound property checks
module test_fast_interrupt_context_swap;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, flags_in, flags_out;
  logic reg_wr = 1'b0, reg_rd = 1'b0, irq_req = 1'b0, instr_end = 1'b0;
  logic global_irq_on_instr = 1'b0, global_irq_off_instr = 1'b0;
  logic interrupt_return_instr = 1'b0;
  logic [2:0] irq_level = 3'h0;
  logic [15:0] pc_in, pc_out, v;
  logic [7:0] b;
  logic irq_ack, fast_taken, entry_busy, entry_done, pc_load, flags_load;
  int error_cnt = 0, n_compared = 0, cyc = 0;

  fics_top dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq_req, .irq_level, .instr_end, .global_irq_on_instr,
    .global_irq_off_instr, .interrupt_return_instr, .pc_in, .flags_in,
    .irq_ack, .fast_taken, .entry_busy, .entry_done, .pc_load, .pc_out,
    .flags_load, .flags_out);
  fics_core_model core_u (.clk, .sys_rst, .pc_load, .pc_out, .flags_load,
    .flags_out, .pc_in, .flags_in);

  // clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rdvp(output logic [15:0] r);
    logic [7:0] h, l;
    rd(8'hDA, h);
    rd(8'hDB, l);
    r = {h, l};
  endtask

  task automatic pulse(input bit on);
    @(posedge clk);
    if (on) global_irq_on_instr <= 1'b1;
    else global_irq_off_instr <= 1'b1;
    @(posedge clk);
    global_irq_on_instr <= 1'b0;
    global_irq_off_instr <= 1'b0;
  endtask

  // one request, then the return unless a expects no ack; f says whether the fast path is expected
  task automatic take(input logic [2:0] l, input logic f, input logic a);
    logic [15:0] p, q;
    int n;
    @(posedge clk);
    irq_level <= l;
    irq_req <= 1'b1;
    instr_end <= 1'b1;
    #1 p = pc_in;
    @(posedge clk);
    irq_req <= 1'b0;
    instr_end <= 1'b0;
    #1 chk("ack", a, irq_ack);
    if (!a) return;
    chk("fast taken", f, fast_taken);
    chk("fast", f, pc_load);
    if (f) chk("entry pc", 16'h1234, pc_out);
    n = 0;
    while (entry_done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    chk("entry length", f ? 16'h0005 : 16'h0015, n);
    rdvp(v);
    if (f) chk("pointer after entry", p, v);
    @(posedge clk);
    interrupt_return_instr <= 1'b1;
    #1 q = pc_in;
    @(posedge clk);
    interrupt_return_instr <= 1'b0;
    #1 chk("swap back", f, pc_load);
    if (f) chk("return pc", p, pc_out);
    if (f) chk("return flags", 8'hA4, flags_out);
    rdvp(v);
    if (f) chk("pointer after return", q, v);
    wr(8'hDA, 8'h12);
    wr(8'hDB, 8'h34);
  endtask

  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(fics_pkg::FICS_ADDR_SYM, b);
    chk("mode reset", 8'h00, b);
    wr(8'hDA, 8'h12);
    wr(8'hDB, 8'h34);
    rdvp(v);
    chk("pointer", 16'h1234, v);
    rd(8'h77, b);
    chk("unmapped", 8'h00, b);
    for (int l = 0; l < 8; l++) begin
      wr(fics_pkg::FICS_ADDR_SYM, {1'b0, l[2:0], 2'h1});
      wr(fics_pkg::FICS_ADDR_SYM, {1'b0, l[2:0], 2'h3});
      take(l[2:0], l != 5, 1'b1);
    end
    wr(fics_pkg::FICS_ADDR_SYM, 8'h09);
    take(3'h2, 1'b0, 1'b1);
    wr(fics_pkg::FICS_ADDR_SYM, 8'h0B);
    pulse(1'b0);
    take(3'h2, 1'b1, 1'b0);
    pulse(1'b1);
    take(3'h2, 1'b1, 1'b1);
    close_out();
  end
endmodule

// ==== logic/fics_cfg_if.sv ====
`timescale 1ns/1ps
// configuration and pointer traffic between top and its register file
interface fics_cfg_if;
  logic [7:0] system_mode_register;
  logic [15:0] vp;
  logic vp_load;
  logic [15:0] vp_new;
  modport regs (output system_mode_register, output vp, input vp_load, input vp_new);
  modport core (input system_mode_register, input vp, output vp_load, output vp_new);
endinterface

// ==== logic/fics_pkg.sv ====
package fics_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] FICS_ADDR_VPH = 8'hDA;
  localparam logic [7:0] FICS_ADDR_VPL = 8'hDB;
  localparam logic [7:0] FICS_ADDR_SYM = 8'hDE;
  // system mode register fields
  localparam int FICS_SYM_GIE = 0;
  localparam int FICS_SYM_FEN = 1;
  localparam int FICS_SYM_SEL_LO = 2;
  localparam int FICS_SYM_SEL_HI = 4;
  localparam logic [7:0] FICS_SYM_RST = 8'h00;
  localparam logic [7:0] FICS_SYM_MASK = 8'h1F;
  // flags register: fast interrupt status bit position
  localparam int FICS_FLAG_FIS = 1;
  // reserved interrupt level
  localparam logic [2:0] FICS_LVL_RSVD = 3'h5;
  // entry cycle counts
  localparam logic [4:0] FICS_FAST_CYC = 5'h06;
  localparam logic [4:0] FICS_NORM_CYC = 5'h16;
  localparam logic [4:0] FICS_CNT_ONE = 5'h01;
  localparam logic [7:0] FICS_VP_RST = 8'h00;
  localparam logic [15:0] FICS_PC_RST = 16'h0000;
  localparam logic [7:0] FICS_FLG_RST = 8'h00;

  typedef enum logic [1:0] {
    FICS_IDLE = 2'b00,
    FICS_FAST = 2'b01,
    FICS_NORM = 2'b10
  } fics_state_t;
endpackage

// ==== logic/fics_regs.sv ====
`timescale 1ns/1ps
// software registers: pointer bytes and system mode register
module fics_regs (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic gie_clr,
  input wire logic gie_set,
  fics_cfg_if.regs cfg
);
  typedef struct packed {
    logic [7:0] vph;
    logic [7:0] vpl;
    logic [7:0] system_mode_register;
  } fics_regs_st_t;
  fics_regs_st_t q, d;

  // hardware swap beats a software write to the same pointer
  always_comb begin
    d = q;
    if (wr) begin
      if (addr == fics_pkg::FICS_ADDR_VPH) begin
        d.vph = wdata;
      end else if (addr == fics_pkg::FICS_ADDR_VPL) begin
        d.vpl = wdata;
      end else if (addr == fics_pkg::FICS_ADDR_SYM) begin
        d.system_mode_register = wdata & fics_pkg::FICS_SYM_MASK;
      end
    end
    if (cfg.vp_load) begin
      d.vph = cfg.vp_new[15:8];
      d.vpl = cfg.vp_new[7:0];
    end
    // hardware set of global enable wins over a clear
    if (gie_clr) d.system_mode_register[fics_pkg::FICS_SYM_GIE] = 1'b0;
    if (gie_set) d.system_mode_register[fics_pkg::FICS_SYM_GIE] = 1'b1;
  end

  // pointer bytes are given a value at reset though software may not rely on it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // any pointer value is legal after reset
      q <= '{fics_pkg::FICS_VP_RST, fics_pkg::FICS_VP_RST,
             fics_pkg::FICS_SYM_RST};
    end else begin
      q <= d;
    end
  end

  assign cfg.system_mode_register = q.system_mode_register;
  assign cfg.vp = {q.vph, q.vpl};
endmodule

// ==== logic/fics_top.sv ====
`timescale 1ns/1ps
// Contract
// - pointer bytes live at DAh and DBh
// - high byte bits 15-8, low 7-0
// - fast entry 6 cycles, normal 22
// - level select in mode bits 4:2
// - fast only while mode bit 1 set
// - any implemented level selectable, 5 reserved
// - entry saves flags to hidden shadow
// - entry swaps program counter and pointer
// - entry sets fast status flag after save
// - return swaps pointer and counter back
// - return restores flags from shadow
// - return clears fast status flag
// - global enable gates fast interrupts too
// - only enable bit turns fast on
// - acknowledge only at instruction end
// - return sets global enable bit
module fics_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  input wire logic instr_end,
  input wire logic global_irq_on_instr,
  input wire logic global_irq_off_instr,
  input wire logic interrupt_return_instr,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  output logic irq_ack,
  output logic fast_taken,
  output logic entry_busy,
  output logic entry_done,
  output logic pc_load,
  output logic [15:0] pc_out,
  output logic flags_load,
  output logic [7:0] flags_out
);
  fics_cfg_if cfg ();
  logic gie_clr;
  logic gie_set;

  typedef struct packed {
    fics_pkg::fics_state_t st;
    logic [4:0] cnt;
    logic [7:0] shadow;
    logic fast_act;
    logic [7:0] rdata;
    logic ack;
    logic fast;
    logic busy;
    logic done;
    logic pcl;
    logic [15:0] pc;
    logic fl;
    logic [7:0] flg;
    logic vpl;
    logic [15:0] vpn;
    logic gclr;
    logic gset;
  } fics_st_t;
  fics_st_t q, d;

  logic [2:0] sel;
  logic fen;
  logic gie;
  logic sel_ok;
  logic take;
  logic fast_hit;

  fics_regs u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .addr(reg_addr),
    .wdata(reg_wdata),
    .wr(reg_wr),
    .gie_clr(gie_clr),
    .gie_set(gie_set),
    .cfg(cfg.regs)
  );

  // decode mode register fields
  always_comb begin
    sel = cfg.system_mode_register[fics_pkg::FICS_SYM_SEL_HI:fics_pkg::FICS_SYM_SEL_LO];
    fen = cfg.system_mode_register[fics_pkg::FICS_SYM_FEN];
    gie = cfg.system_mode_register[fics_pkg::FICS_SYM_GIE];
    sel_ok = (sel != fics_pkg::FICS_LVL_RSVD);
    // requests wait for the instruction boundary and global enable
    take = irq_req && instr_end && gie && !global_irq_off_instr
           && q.st == fics_pkg::FICS_IDLE;
    // fast handling needs the enable bit, a non-reserved select and a request level equal to it
    fast_hit = fen && sel_ok && irq_level == sel;
  end

  // entry and return sequencing
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.done = 1'b0;
    d.pcl = 1'b0;
    d.fl = 1'b0;
    d.vpl = 1'b0;
    d.gclr = 1'b0;
    d.gset = 1'b0;
    d.rdata = q.rdata;
    if (reg_rd) begin
      // reads of the mode register show live enable state
      if (reg_addr == fics_pkg::FICS_ADDR_VPH) begin
        d.rdata = cfg.vp[15:8];
      end else if (reg_addr == fics_pkg::FICS_ADDR_VPL) begin
        d.rdata = cfg.vp[7:0];
      end else if (reg_addr == fics_pkg::FICS_ADDR_SYM) begin
        d.rdata = cfg.system_mode_register;
      end else begin
        d.rdata = 8'h00;
      end
    end
    if (global_irq_on_instr) d.gset = 1'b1;
    if (global_irq_off_instr) d.gclr = 1'b1;
    case (q.st)
      fics_pkg::FICS_IDLE: begin
        if (take) begin
          d.ack = 1'b1;
          d.busy = 1'b1;
          d.gclr = 1'b1;
          d.gset = 1'b0;
          d.fast = fast_hit;
          if (fast_hit) begin
            d.st = fics_pkg::FICS_FAST;
            d.cnt = fics_pkg::FICS_FAST_CYC - fics_pkg::FICS_CNT_ONE;
            d.shadow = flags_in;
            d.pc = cfg.vp;
            d.pcl = 1'b1;
            d.vpn = pc_in;
            d.vpl = 1'b1;
            d.flg = flags_in;
            d.flg[fics_pkg::FICS_FLAG_FIS] = 1'b1;
            d.fl = 1'b1;
            d.fast_act = 1'b1;
          end else begin
            d.st = fics_pkg::FICS_NORM;
            d.cnt = fics_pkg::FICS_NORM_CYC - fics_pkg::FICS_CNT_ONE;
          end
        end else if (interrupt_return_instr) begin
          d.gset = 1'b1;
          d.gclr = 1'b0;
          // fast end needs the live status flag, not just our copy
          if (q.fast_act && flags_in[fics_pkg::FICS_FLAG_FIS]) begin
            d.pc = cfg.vp;
            d.pcl = 1'b1;
            d.vpn = pc_in;
            d.vpl = 1'b1;
            d.flg = q.shadow;
            d.flg[fics_pkg::FICS_FLAG_FIS] = 1'b0;
            d.fl = 1'b1;
            d.fast_act = 1'b0;
          end
        end
      end
      fics_pkg::FICS_FAST, fics_pkg::FICS_NORM: begin
        // count out the entry cycles the core sequencer must wait
        if (q.cnt == fics_pkg::FICS_CNT_ONE) begin
          d.st = fics_pkg::FICS_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end
        d.cnt = q.cnt - fics_pkg::FICS_CNT_ONE;
      end
      default: begin
        d.st = fics_pkg::FICS_IDLE;
      end
    endcase
  end

  // state register; shadow flags are internal only and not addressable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '{fics_pkg::FICS_IDLE, 5'h00, fics_pkg::FICS_FLG_RST, 1'b0,
             8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, fics_pkg::FICS_PC_RST,
             1'b0, fics_pkg::FICS_FLG_RST, 1'b0, fics_pkg::FICS_PC_RST,
             1'b0, 1'b0};
    end else begin
      q <= d;
    end
  end

  // pointer update and enable changes reach the register file one cycle after the decision, the registers a cycle later
  assign cfg.vp_load = q.vpl;
  assign cfg.vp_new = q.vpn;
  assign gie_clr = q.gclr;
  assign gie_set = q.gset;

  assign reg_rdata = q.rdata;
  assign irq_ack = q.ack;
  assign fast_taken = q.fast;
  assign entry_busy = q.busy;
  assign entry_done = q.done;
  assign pc_load = q.pcl;
  assign pc_out = q.pc;
  assign flags_load = q.fl;
  assign flags_out = q.flg;
endmodule
